// ===== src/dacms_pkg.sv
// Overview of operation
// - with reset pin held high, serial pins act as static mode straps.
// - after reset, configure from strap levels sampled in the first cycle after reset is released.
// - while override is high the four config straps are ignored; only format comes from a register.
// - global power-down pin high forces power-down, else register bit rules in combined mode, clock/data straps in pin mode.
// - combined mode coarse gain from register only when override high, else 0 dB.
// - combined mode reference choice comes from the register bit, not pin.
// - combined mode patterns come from registers, not pins; power-down comes from registers or pins.
// - clock/data strap pair picks normal, sync, power-down or deskew.
// - select strap level picks reference source and coarse gain.
// - channel power-down pin high powers that channel's converter down.
// - channel strap levels apply after power-up in every mode, config straps unless override is high.
// - first config strap picks bit clock rate and wire count.
// - second config strap picks serialization factor and capture edge.
// - fourth config strap picks bit order and data format.
// - soft reset restores all register defaults and then clears itself.
package dacms_pkg;
  // four-level strap codes
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_3_8 = 2'h1;
  localparam logic [1:0] LVL_5_8 = 2'h2;
  localparam logic [1:0] LVL_FULL = 2'h3;
  // register offsets and field positions
  localparam logic [4:0] ADDR_GENERAL = 5'h00;
  localparam logic [4:0] ADDR_PATTERN = 5'h0a;
  localparam logic [4:0] ADDR_OVERRIDE = 5'h0d;
  localparam int SOFT_RESET_BIT = 10;
  localparam int REF_BIT = 6;
  localparam int PD_CHB_BIT = 3;
  localparam int PD_CHA_BIT = 2;
  localparam int PD_GLOBAL_BIT = 0;
  localparam int FORMAT_BIT = 9;
  localparam int PATTERN_HI = 7;
  localparam int PATTERN_LO = 5;
  localparam int OVERRIDE_BIT = 10;
  localparam int GAIN_BIT = 5;
  localparam int OVR_CFG_LO = 0;
  localparam int REG_COUNT = 32;
  localparam logic [10:0] REG_DEFAULT = 11'h000;
  // pattern field codes
  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_DESKEW = 3'h1;
  localparam logic [2:0] PAT_SYNC = 3'h2;

  typedef enum logic [1:0] {
    DACMS_MODE_NORMAL = 2'b00,
    DACMS_MODE_SYNC = 2'b01,
    DACMS_MODE_PDN = 2'b10,
    DACMS_MODE_DESKEW = 2'b11
  } dacms_pattern_t;

  typedef enum logic [1:0] {
    DACMS_ST_SAMPLE = 2'b00,
    DACMS_ST_RUN = 2'b01,
    DACMS_ST_CLEAR = 2'b10
  } dacms_state_t;

  typedef struct packed {
    logic [1:0] serial_select_pin;
    logic [1:0] serial_clock_pin;
    logic [1:0] serial_shift_data_pin;
    logic [1:0] interface_width_strap;
    logic [1:0] serialization_edge_strap;
    logic [1:0] reserved_strap;
    logic [1:0] bit_order_format_strap;
    logic channel_a_powerdown_pin;
    logic channel_b_powerdown_pin;
  } dacms_straps_t;

  typedef struct packed {
    logic two_wire;
    logic sdr_clock;
    logic ser_14x;
    logic rising_edge;
    logic lsb_first;
    logic offset_binary;
    logic internal_ref;
    logic gain_3p5db;
    logic global_pdn;
    logic chan_a_pdn;
    logic chan_b_pdn;
    dacms_pattern_t pattern;
  } dacms_cfg_t;
endpackage

// ===== src/dacms_regfile.sv
`timescale 1ns/1ns
`default_nettype none
// small register store; soft reset clears every word back to default
module dacms_regfile
  import dacms_pkg::*;
#(
  parameter int DEPTH = REG_COUNT
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [10:0] wr_data,
  output logic [DEPTH*11-1:0] words
);
  logic [DEPTH*11-1:0] words_reg;
  logic [DEPTH*11-1:0] words_next;

  // one word per address, all held in flops so the decoder sees them at once
  always_comb begin
    words_next = words_reg;
    for (int i = 0; i < DEPTH; i++) begin
      if (clear) begin
        words_next[i*11 +: 11] = REG_DEFAULT;
      end else if (wr_en && wr_addr == 5'(i)) begin
        words_next[i*11 +: 11] = wr_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      words_reg <= {DEPTH{REG_DEFAULT}};
    end else begin
      words_reg <= words_next;
    end
  end

  assign words = words_reg;
endmodule
`default_nettype wire

// ===== src/dacms_strap_decode.sv
`timescale 1ns/1ns
`default_nettype none
// pure pin-level decode of the captured straps
module dacms_strap_decode
  import dacms_pkg::*;
(
  input wire dacms_straps_t straps,
  output dacms_cfg_t cfg
);
  always_comb begin
    cfg = '0;
    // first strap: ground is ddr one-wire, 5/8 sdr two-wire, full ddr two-wire
    cfg.two_wire = (straps.interface_width_strap == LVL_5_8) ||
                   (straps.interface_width_strap == LVL_FULL);
    cfg.sdr_clock = (straps.interface_width_strap == LVL_5_8);
    // second strap: middle levels give 14x, upper half rising edge in two-wire sdr
    cfg.ser_14x = (straps.serialization_edge_strap == LVL_3_8) ||
                  (straps.serialization_edge_strap == LVL_5_8);
    cfg.rising_edge = straps.serialization_edge_strap[1] &&
                      cfg.two_wire && cfg.sdr_clock;
    // fourth strap: upper half lsb first, middle levels offset binary
    cfg.lsb_first = straps.bit_order_format_strap[1];
    cfg.offset_binary = (straps.bit_order_format_strap == LVL_3_8) ||
                        (straps.bit_order_format_strap == LVL_5_8);
    // select strap: upper half internal ref, middle levels 3.5 db
    cfg.internal_ref = straps.serial_select_pin[1];
    cfg.gain_3p5db = (straps.serial_select_pin == LVL_3_8) ||
                     (straps.serial_select_pin == LVL_5_8);
    // clock/data pair: high bit of each code stands for a logic high
    cfg.pattern = dacms_pattern_t'({straps.serial_clock_pin[1],
                                    straps.serial_shift_data_pin[1]});
    cfg.global_pdn = (cfg.pattern == DACMS_MODE_PDN);
    cfg.chan_a_pdn = straps.channel_a_powerdown_pin;
    cfg.chan_b_pdn = straps.channel_b_powerdown_pin;
  end
endmodule
`default_nettype wire

// ===== src/dacms_top.sv
`timescale 1ns/1ns
`default_nettype none
// mode selection between straps and serial registers
module dacms_top
  import dacms_pkg::*;
#(
  parameter int DEPTH = REG_COUNT
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hw_reset_pin,
  input wire logic global_powerdown_pin,
  input wire dacms_straps_t straps_in,
  input wire logic reg_wr_en,
  input wire logic [4:0] reg_wr_addr,
  input wire logic [10:0] reg_wr_data,
  output dacms_cfg_t cfg_out,
  output logic pin_control_mode,
  output logic cfg_valid
);
  typedef struct packed {
    dacms_state_t state;
    dacms_straps_t straps;
    logic pin_mode;
    logic soft_clear;
    dacms_cfg_t cfg;
  } dacms_top_state_t;

  dacms_top_state_t st_reg;
  dacms_top_state_t st_next;
  dacms_cfg_t pin_cfg;
  logic [DEPTH*11-1:0] words;
  logic [10:0] w_general;
  logic [10:0] w_pattern;
  logic [10:0] w_override;
  logic reg_clear;
  logic wr_ok;

  // writes only count while the serial port is live (reset pin low)
  assign wr_ok = reg_wr_en && !hw_reset_pin && st_reg.state == DACMS_ST_RUN;
  // hardware reset pulse or self-clearing soft reset restores defaults
  assign reg_clear = st_reg.soft_clear || hw_reset_pin;

  dacms_regfile #(
    .DEPTH(DEPTH)
  ) u_regs (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(reg_clear),
    .wr_en(wr_ok),
    .wr_addr(reg_wr_addr),
    .wr_data(reg_wr_data),
    .words(words)
  );

  dacms_strap_decode u_dec (
    .straps(st_reg.straps),
    .cfg(pin_cfg)
  );

  assign w_general = words[ADDR_GENERAL*11 +: 11];
  assign w_pattern = words[ADDR_PATTERN*11 +: 11];
  assign w_override = words[ADDR_OVERRIDE*11 +: 11];

  // state update: capture straps once, then arbitrate continuously
  always_comb begin
    logic ovrd;
    logic [2:0] pat;
    ovrd = 1'b0;
    pat = 3'h0;
    st_next = st_reg;
    st_next.soft_clear = 1'b0;
    case (st_reg.state)
      DACMS_ST_SAMPLE: begin
        // straps latched once; later wiggles are ignored by design
        st_next.straps = straps_in;
        st_next.state = DACMS_ST_RUN;
      end
      DACMS_ST_RUN: begin
        // a soft reset write takes effect next cycle, then self-clears
        if (wr_ok && reg_wr_addr == ADDR_GENERAL &&
            reg_wr_data[SOFT_RESET_BIT]) begin
          st_next.soft_clear = 1'b1;
          st_next.state = DACMS_ST_CLEAR;
        end
      end
      DACMS_ST_CLEAR: begin
        st_next.state = DACMS_ST_RUN;
      end
      default: begin
        st_next.state = DACMS_ST_SAMPLE;
      end
    endcase
    // reset pin tied high means serial pins are straps
    st_next.pin_mode = hw_reset_pin;
    ovrd = w_override[OVERRIDE_BIT];
    pat = w_pattern[PATTERN_HI:PATTERN_LO];
    if (st_next.pin_mode) begin
      st_next.cfg = pin_cfg;
    end else begin
      // config straps unless override; tie-to-ground relies on the board
      st_next.cfg = pin_cfg;
      if (ovrd) begin
        // override: config fields from registers; only format is mapped
        st_next.cfg.offset_binary = !w_pattern[FORMAT_BIT];
        st_next.cfg.two_wire = 1'b1;
        st_next.cfg.sdr_clock = 1'b0;
        st_next.cfg.ser_14x = 1'b0;
        st_next.cfg.rising_edge = 1'b0;
        st_next.cfg.lsb_first = 1'b0;
        st_next.cfg.gain_3p5db = w_override[GAIN_BIT];
      end else begin
        st_next.cfg.gain_3p5db = 1'b0;
      end
      st_next.cfg.internal_ref = w_general[REF_BIT];
      // pattern field replaces the clock/data pin pair
      if (pat == PAT_SYNC) begin
        st_next.cfg.pattern = DACMS_MODE_SYNC;
      end else if (pat == PAT_DESKEW) begin
        st_next.cfg.pattern = DACMS_MODE_DESKEW;
      end else begin
        st_next.cfg.pattern = DACMS_MODE_NORMAL;
      end
      // channel pins stay live; register bits add to them
      st_next.cfg.chan_a_pdn = pin_cfg.chan_a_pdn || w_general[PD_CHA_BIT];
      st_next.cfg.chan_b_pdn = pin_cfg.chan_b_pdn || w_general[PD_CHB_BIT];
      st_next.cfg.global_pdn = w_general[PD_GLOBAL_BIT];
    end
    // pdn pin high always wins over the register bit
    if (global_powerdown_pin) begin
      st_next.cfg.global_pdn = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg_out = st_reg.cfg;
  assign pin_control_mode = st_reg.pin_mode;
  // valid once straps have been captured, one cycle before the settings reflect them
  assign cfg_valid = st_reg.state != DACMS_ST_SAMPLE;
endmodule
`default_nettype wire

// ===== verif/dacms_checker.sv
`timescale 1ns/1ns
`default_nettype none
// port-level checks of the strap decode and pin priority
module dacms_checker
  import dacms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hw_reset_pin,
  input wire logic global_powerdown_pin,
  input wire dacms_straps_t straps_in,
  input wire dacms_cfg_t cfg_out,
  input wire logic pin_control_mode,
  input wire logic cfg_valid
);
  dacms_straps_t cap;
  logic arm, pm_d, pm;
  // mirror of the one-shot capture; later strap wiggles must not count
  always_ff @(posedge ref_clk) begin
    arm <= reset;
    pm_d <= pin_control_mode;
    if (arm && !reset) cap <= straps_in;
  end
  assign pm = cfg_valid && pin_control_mode && pm_d;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_valid; $fell(reset) |-> ##1 cfg_valid; endproperty
  a_valid: assert property (p_valid)
    else $error("cfg_valid late after reset");
  property p_mode; hw_reset_pin |=> pin_control_mode; endproperty
  a_mode: assert property (p_mode)
    else $error("pin control mode not taken");
  property p_ref; pm |-> {cfg_out.internal_ref, cfg_out.gain_3p5db} ==
    {cap.serial_select_pin[1], ^cap.serial_select_pin}; endproperty
  a_ref: assert property (p_ref)
    else $error("select strap decode wrong");
  property p_wid; pm && cap.interface_width_strap != LVL_3_8 |->
    cfg_out.two_wire == (cap.interface_width_strap != LVL_GND) &&
    cfg_out.sdr_clock == (cap.interface_width_strap == LVL_5_8); endproperty
  a_wid: assert property (p_wid)
    else $error("width strap decode wrong");
  property p_ser; pm |-> cfg_out.ser_14x == ^cap.serialization_edge_strap;
  endproperty
  a_ser: assert property (p_ser)
    else $error("serialization strap decode wrong");
  property p_fmt; pm |-> {cfg_out.lsb_first, cfg_out.offset_binary} ==
    {cap.bit_order_format_strap[1], ^cap.bit_order_format_strap}; endproperty
  a_fmt: assert property (p_fmt)
    else $error("order strap decode wrong");
  property p_pat; pm |-> cfg_out.pattern ==
    {cap.serial_clock_pin[1], cap.serial_shift_data_pin[1]}; endproperty
  a_pat: assert property (p_pat)
    else $error("pattern pin decode wrong");
  property p_gpd; global_powerdown_pin [*3] |-> cfg_out.global_pdn;
  endproperty
  a_gpd: assert property (p_gpd)
    else $error("global power-down pin ignored");
  property p_chan; cfg_valid && $past(cfg_valid) &&
    cap.channel_a_powerdown_pin |-> cfg_out.chan_a_pdn; endproperty
  a_chan: assert property (p_chan)
    else $error("channel power-down pin ignored");
  c_pin: cover property (pm && cfg_out.pattern == DACMS_MODE_DESKEW);
  c_gpd: cover property (!pin_control_mode && global_powerdown_pin);
  c_sync: cover property (!pm && cfg_out.pattern == DACMS_MODE_SYNC);
endmodule
bind dacms_top dacms_checker u_chk (.ref_clk(ref_clk), .reset(reset),
  .hw_reset_pin(hw_reset_pin), .global_powerdown_pin(global_powerdown_pin),
  .straps_in(straps_in), .cfg_out(cfg_out),
  .pin_control_mode(pin_control_mode), .cfg_valid(cfg_valid));
`default_nettype wire

// ===== verif/dacms_ctl.sv
`timescale 1ns/1ns
`default_nettype none
// board straps plus the external controller's register writer
module dacms_ctl
  import dacms_pkg::*;
(
  input wire logic ref_clk,
  output dacms_straps_t straps,
  output logic hw_pin,
  output logic gpd_pin,
  output logic wr_en,
  output logic [4:0] wr_addr,
  output logic [10:0] wr_data
);
  initial begin
    straps = '0;
    hw_pin = 1'b1;
    gpd_pin = 1'b0;
    wr_en = 1'b0;
    wr_addr = 5'h00;
    wr_data = 11'h000;
  end
  // board levels; the reserved strap is never left floating
  task automatic set(input dacms_straps_t s, input logic h, input logic g);
    s.reserved_strap = LVL_GND;
    @(posedge ref_clk);
    straps <= s;
    hw_pin <= h;
    gpd_pin <= g;
  endtask
  // one strobe; released lines show garbage, not the last word
  task automatic wr(input logic [4:0] a, input logic [10:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== verif/dual_adc_config_mode_select_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dual_adc_config_mode_select_tb
  import dacms_pkg::*;
;
  logic ref_clk, reset, hw, gpd, we, pcm, vld;
  logic [4:0] wa;
  logic [10:0] wd;
  dacms_straps_t st;
  dacms_cfg_t cfg;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int r [32];
  dacms_ctl u_ctl (.ref_clk(ref_clk), .straps(st), .hw_pin(hw),
    .gpd_pin(gpd), .wr_en(we), .wr_addr(wa), .wr_data(wd));
  dacms_top dut (.ref_clk(ref_clk), .reset(reset), .hw_reset_pin(hw),
    .global_powerdown_pin(gpd), .straps_in(st), .reg_wr_en(we),
    .reg_wr_addr(wa), .reg_wr_data(wd), .cfg_out(cfg),
    .pin_control_mode(pcm), .cfg_valid(vld));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // the tests need a few hundred cycles; a hang is cut short at 2000
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // straps are latched once, so each new strap set needs a reset
  task automatic rst(input dacms_straps_t s, input logic h, input logic g);
    u_ctl.set(s, h, g);
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    r = '{default: 0};
  endtask
  // writes are refused in pin mode; soft reset clears every word
  task automatic wrt(input int a, input int d);
    u_ctl.wr(a[4:0], d[10:0]);
    if (!hw && a == 0 && d[10]) r = '{default: 0};
    else if (!hw) r[a] = d;
    repeat (2) @(posedge ref_clk);
  endtask
  // reference model; edge choice only matters in two-wire sdr
  task automatic chk();
    dacms_cfg_t e, m;
    logic ovr;
    logic [1:0] w;
    int p;
    e = '0;
    m = '1;
    ovr = !hw && r[13][10];
    w = st.interface_width_strap;
    p = r[10][7:5];
    e.two_wire = ovr || w != LVL_GND;
    e.sdr_clock = !ovr && w == LVL_5_8;
    e.ser_14x = !ovr && ^st.serialization_edge_strap;
    e.rising_edge = st.serialization_edge_strap[1];
    m.rising_edge = !ovr && w == LVL_5_8;
    e.lsb_first = !ovr && st.bit_order_format_strap[1];
    // under override a set format bit selects two's complement
    e.offset_binary = ovr ? !r[10][9] : ^st.bit_order_format_strap;
    e.internal_ref = hw ? st.serial_select_pin[1] : r[0][6];
    e.gain_3p5db = hw ? ^st.serial_select_pin : ovr && r[13][5];
    w = {st.serial_clock_pin[1], st.serial_shift_data_pin[1]};
    if (hw) e.pattern = dacms_pattern_t'(w);
    else if (p == 2) e.pattern = DACMS_MODE_SYNC;
    else if (p == 1) e.pattern = DACMS_MODE_DESKEW;
    e.global_pdn = gpd || (hw ? e.pattern == DACMS_MODE_PDN : r[0][0]);
    e.chan_a_pdn = st.channel_a_powerdown_pin || r[0][2];
    e.chan_b_pdn = st.channel_b_powerdown_pin || r[0][3];
    @(negedge ref_clk);
    n_tests++;
    if ((cfg & m) !== (e & m)) begin
      error_cnt++;
      $display("wrong value cfg_out exp %h got %h", e, cfg);
    end
    n_tests++;
    if (pcm !== hw) begin
      error_cnt++;
      $display("wrong value pin_control_mode exp %b got %b", hw, pcm);
    end
    n_tests++;
    if (vld !== 1'b1) begin
      error_cnt++;
      $display("wrong value cfg_valid exp 1 got %b", vld);
    end
  endtask
  initial begin
    dacms_straps_t s;
    reset = 1'b1;
    void'($urandom(32'hf033));
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    // pin mode: every level of each strap but width strap 3/8 and the reserved strap, random pins around them
    for (int i = 0; i < 16; i++) begin
      s = dacms_straps_t'(16'($urandom));
      s.serial_select_pin = i[1:0];
      s.serial_clock_pin[1] = i[2];
      s.serial_shift_data_pin[1] = i[3];
      s.serialization_edge_strap = i[3:2];
      s.bit_order_format_strap = i[1:0] ^ i[3:2];
      s.interface_width_strap = (i % 3 == 0) ? LVL_GND :
        (i % 3 == 1) ? LVL_5_8 : LVL_FULL;
      rst(s, 1'b1, 1'($urandom));
      chk();
      wrt(0, 11'h045);
      chk();
    end
    $display("test pin mode done");
    s = dacms_straps_t'(16'($urandom));
    s.interface_width_strap = LVL_5_8;
    s.serial_select_pin = LVL_5_8;
    rst(s, 1'b0, 1'b0);
    chk();
    // all eight pattern codes, the unused ones must read as normal
    for (int p = 0; p < 8; p++) begin
      wrt(5'h0a, p << 5 | ($urandom & 11'h200));
      wrt(0, $urandom & 11'h04d);
      wrt(5'h05, $urandom & 11'h3ff);
      chk();
    end
    u_ctl.set(s, 1'b0, 1'b1);
    repeat (3) @(posedge ref_clk);
    chk();
    $display("test combined done");
    rst(s, 1'b0, 1'b0);
    wrt(5'h0d, 11'h420);
    wrt(5'h0a, 11'h200);
    chk();
    wrt(5'h0d, 11'h400);
    chk();
    $display("test override done");
    rst('0, 1'b0, 1'b0);
    wrt(5'h0d, 11'h420);
    wrt(5'h0a, 11'h040);
    wrt(0, 11'h441);
    chk();
    wrt(5'h0a, 11'h040);
    chk();
    $display("test soft reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
